// ==== link_shifter.sv ====
`timescale 1ns/1ps
module link_shifter
  import spi_pkg::*;
(
  input wire logic sclk, // serial clock from the external master
  input wire logic rst, // bus-side reset, asserted asynchronously
  input wire logic ss_n, // slave select pin, active low
  input wire logic len16, // quasi-static length select
  input wire logic din, // serial data in (already routed by mode)
  input wire logic [WORD_W-1:0] tx_word, // held stable by bus side while selected
  output logic [WORD_W-1:0] rx_word, // last complete word
  output logic done_tog, // toggles once per complete word
  output logic dout // serial data out
);
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [WORD_W-1:0] sh_r;
  logic [WORD_W-1:0] sh_nxt;
  logic [WORD_W-1:0] rx_r;
  logic [WORD_W-1:0] rx_nxt;
  logic tog_r;
  logic tog_nxt;
  logic dout_r;
  logic [CNT_W-1:0] top;
  logic last;
  logic [CNT_W-1:0] idx;
  logic clr;

  assign top = len16 ? TOP_BIT_16 : TOP_BIT_8;
  assign last = (cnt_r == top);
  assign idx = top - cnt_r;
  // deselect restarts the bit count; the clock may stand still outside frames
  assign clr = rst | ss_n;

  // ==========================================================
  // shift-in on the trailing edge, word completes on the last bit
  always_comb begin
    cnt_nxt = last ? '0 : cnt_r + 5'h01;
    sh_nxt = {sh_r[WORD_W-2:0], din};
    rx_nxt = rx_r;
    tog_nxt = tog_r;
    if (last) begin
      rx_nxt = len16 ? sh_nxt : (sh_nxt & LOW_BYTE_MASK);
      tog_nxt = ~tog_r;
    end
  end

  always_ff @(negedge sclk or posedge clr) begin
    if (clr) begin
      cnt_r <= '0;
      sh_r <= DATA_RESET;
    end else begin
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
    end
  end

  always_ff @(negedge sclk or posedge rst) begin
    if (rst) begin
      rx_r <= DATA_RESET;
      tog_r <= 1'b0;
    end else begin
      rx_r <= rx_nxt;
      tog_r <= tog_nxt;
    end
  end

  // ==========================================================
  // drive the next bit on the leading edge of each bit time
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      dout_r <= 1'b0;
    end else begin
      dout_r <= tx_word[idx[3:0]];
    end
  end

  assign rx_word = rx_r;
  assign done_tog = tog_r;
  assign dout = dout_r;
endmodule // link_shifter

// ==== spi_core.sv ====
`timescale 1ns/1ps
module spi_core
  import spi_pkg::*;
#(
  parameter int HALF_CYCLES = HALF_BIT_CYCLES
) (
  input wire logic mclk, // bus clock
  input wire logic reset, // synchronous, active high
  input wire logic sclk_in, // serial clock pin input, link clock
  output logic sclk_out, // serial clock pin output
  output logic sclk_oe, // serial clock pin drive enable
  input wire logic mosi_in, // master-out pin input
  output logic mosi_out, // master-out pin output
  output logic mosi_oe, // master-out pin drive enable
  input wire logic miso_in, // master-in pin input
  output logic miso_out, // master-in pin output
  output logic miso_oe, // master-in pin drive enable
  input wire logic ss_n_in, // slave select pin input
  output logic ss_n_out, // slave select pin output
  output logic ss_n_oe, // slave select pin drive enable
  input wire logic ctrl1_wr, // control register one write strobe
  input wire logic wr_system_enable, // written value
  input wire logic wr_master_select, // written value
  input wire logic wr_main_irq_mask, // written value
  input wire logic wr_transmit_irq_mask, // written value
  input wire logic wr_select_output_enable, // written value
  input wire logic ctrl2_wr, // control register two write strobe
  input wire logic wr_match_irq_mask, // written value
  input wire logic wr_len16, // written value, 16-bit words
  input wire logic wr_mode_fault_enable, // written value
  input wire logic wr_bidir_output_enable, // written value
  input wire logic wr_stop_in_wait, // written value
  input wire logic wr_bidir_select, // written value
  input wire logic status_rd, // status register read strobe
  input wire logic data_wr, // data register write strobe
  input wire logic [WORD_W-1:0] data_wdata, // data to send
  input wire logic data_rd, // data register read strobe
  input wire logic match_wr, // match register write strobe
  input wire logic [WORD_W-1:0] match_wdata, // match value
  input wire logic wait_mode, // cpu in wait
  input wire logic stop3_mode, // cpu in stop3
  input wire logic deep_stop, // cpu in a deeper stop
  output logic system_enable, // module enabled
  output logic master_select, // master role
  output logic bidir_output_enable, // shared pin drives
  output logic receive_full_flag, // receive buffer full
  output logic transmit_empty_flag, // transmit buffer empty
  output logic match_flag, // receive buffer equals match
  output logic mode_fault_flag, // mode fault seen
  output logic [WORD_W-1:0] rx_data, // receive data buffer
  output logic irq // interrupt request
);
  localparam logic [DIV_W-1:0] HALF_LAST = DIV_W'(HALF_CYCLES - 1);

  // ==========================================================
  // control and status state
  logic en_r, en_nxt, mst_r, mst_nxt, mie_r, mie_nxt, tie_r, tie_nxt;
  logic soe_r, soe_nxt, mmie_r, mmie_nxt, len_r, len_nxt, mfe_r, mfe_nxt;
  logic boe_r, boe_nxt, siw_r, siw_nxt, bsel_r, bsel_nxt;
  logic rxf_r, rxf_nxt, txe_r, txe_nxt, mf_r, mf_nxt, mode_fault_flag_r, mode_fault_flag_nxt;
  logic arm_rx_r, arm_rx_nxt, arm_tx_r, arm_tx_nxt;
  logic arm_mf_r, arm_mf_nxt, arm_mode_fault_flag_r, arm_mode_fault_flag_nxt;
  logic txfull_r, txfull_nxt, irq_r, irq_nxt;
  logic [WORD_W-1:0] txbuf_r, txbuf_nxt, rxbuf_r, rxbuf_nxt;
  logic [WORD_W-1:0] match_r, match_nxt, slv_word_r, slv_word_nxt;
  // master sequencer state
  mstate_type st_r, st_nxt;
  logic [DIV_W-1:0] div_r, div_nxt;
  logic [CNT_W-1:0] bit_r, bit_nxt;
  logic [WORD_W-1:0] msh_r, msh_nxt;
  logic sclk_r, sclk_nxt, mout_r, mout_nxt;
  // pin enables
  logic sclk_oe_r, sclk_oe_nxt, mosi_oe_r, mosi_oe_nxt, miso_oe_r, miso_oe_nxt;
  logic ss_oe_r, ss_oe_nxt, ss_out_r, ss_out_nxt;
  // link crossing
  logic tog_prev_r, tog_prev_nxt;
  logic [2:0] pins_s;
  logic ss_s, mosi_s, miso_s, tog_s, tog_q;
  logic link_tog;
  logic [WORD_W-1:0] link_word;
  logic link_dout, link_din;
  // decode helpers
  logic rst_all, frozen, m_act, s_act, fault, rx_ev, m_done;
  logic [WORD_W-1:0] rx_word, m_word;
  logic [CNT_W-1:0] top;
  logic m_din;

  // deeper stop returns everything to defaults like a reset
  assign rst_all = reset | deep_stop;
  // wait with stop-in-wait or stop3 holds the bus-side core still
  assign frozen = (wait_mode & siw_r) | stop3_mode;
  assign m_act = en_r & mst_r;
  assign s_act = en_r & ~mst_r & ~mode_fault_flag_r;
  assign top = len_r ? TOP_BIT_16 : TOP_BIT_8;

  // ==========================================================
  // pin synchronisers and the slave shifter on the link clock
  sync2 #(.W(3)) u_sync (
    .mclk(mclk),
    .reset(rst_all),
    .d({ss_n_in, mosi_in, miso_in}),
    .q(pins_s)
  );

  // the synchroniser resets high, so it carries the inverse: no false word after reset
  sync2 #(.W(1)) u_tog_sync (
    .mclk(mclk),
    .reset(rst_all),
    .d(~link_tog),
    .q(tog_q)
  );
  assign tog_s = ~tog_q;

  assign ss_s = pins_s[2];
  assign mosi_s = pins_s[1];
  assign miso_s = pins_s[0];
  // slave in bidir mode listens on its own shared pin
  assign link_din = bsel_r ? miso_in : mosi_in;
  // master in bidir mode listens on the pin it drives
  assign m_din = bsel_r ? mosi_s : miso_s;

  link_shifter u_link (
    .sclk(sclk_in),
    .rst(rst_all),
    .ss_n(ss_n_in),
    .len16(len_r),
    .din(link_din),
    .tx_word(slv_word_r),
    .rx_word(link_word),
    .done_tog(link_tog),
    .dout(link_dout)
  );

  // fault: master sees select low, detection on, automatic select off
  assign fault = m_act & mfe_r & ~soe_r & ~ss_s;

  // ==========================================================
  // master sequencer: one bit per two half periods
  always_comb begin
    st_nxt = st_r;
    div_nxt = div_r;
    bit_nxt = bit_r;
    msh_nxt = msh_r;
    sclk_nxt = sclk_r;
    mout_nxt = mout_r;
    m_done = 1'b0;
    m_word = msh_r;
    unique case (st_r)
      ST_IDLE: begin
        div_nxt = '0;
        bit_nxt = '0;
        sclk_nxt = 1'b0;
        if (m_act & txfull_r & ~frozen & ~fault) begin
          msh_nxt = txbuf_r;
          st_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        // a frozen master keeps clock level, counters and data as they are
        if (!frozen) begin
          div_nxt = div_r + 8'h01;
          if (div_r == HALF_LAST) begin
            div_nxt = '0;
            if (!sclk_r) begin
              sclk_nxt = 1'b1;
              mout_nxt = msh_r[top[3:0]];
            end else begin
              sclk_nxt = 1'b0;
              msh_nxt = {msh_r[WORD_W-2:0], m_din};
              bit_nxt = bit_r + 5'h01;
              if (bit_r == top) begin
                m_done = 1'b1;
                m_word = len_r ? msh_nxt : (msh_nxt & LOW_BYTE_MASK);
                st_nxt = ST_IDLE;
              end
            end
          end
        end
      end
    endcase
    // fault or disable aborts to idle at once
    if (fault | ~m_act) begin
      st_nxt = ST_IDLE;
      sclk_nxt = 1'b0;
      m_done = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst_all) begin
      st_r <= ST_IDLE;
      div_r <= '0;
      bit_r <= '0;
      msh_r <= DATA_RESET;
      sclk_r <= 1'b0;
      mout_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      div_r <= div_nxt;
      bit_r <= bit_nxt;
      msh_r <= msh_nxt;
      sclk_r <= sclk_nxt;
      mout_r <= mout_nxt;
    end
  end

  // ==========================================================
  // master and slave word completions; a frozen core leaves the slave event pending
  assign rx_ev = m_done | ((tog_s != tog_prev_r) & ~frozen & en_r);
  assign rx_word = m_done ? m_word : link_word;

  // ==========================================================
  // registers, flags and their read-then-access clearing
  always_comb begin
    en_nxt = en_r;
    mst_nxt = mst_r;
    mie_nxt = mie_r;
    tie_nxt = tie_r;
    soe_nxt = soe_r;
    mmie_nxt = mmie_r;
    len_nxt = len_r;
    mfe_nxt = mfe_r;
    boe_nxt = boe_r;
    siw_nxt = siw_r;
    bsel_nxt = bsel_r;
    txbuf_nxt = txbuf_r;
    txfull_nxt = txfull_r;
    rxbuf_nxt = rxbuf_r;
    match_nxt = match_r;
    slv_word_nxt = slv_word_r;
    tog_prev_nxt = frozen ? tog_prev_r : tog_s;
    // clears first; sets below win in the same cycle
    arm_rx_nxt = status_rd ? rxf_r : arm_rx_r;
    arm_tx_nxt = status_rd ? txe_r : arm_tx_r;
    arm_mf_nxt = status_rd ? mf_r : arm_mf_r;
    arm_mode_fault_flag_nxt = status_rd ? mode_fault_flag_r : arm_mode_fault_flag_r;
    rxf_nxt = rxf_r & ~(data_rd & arm_rx_r);
    mf_nxt = mf_r & ~(data_rd & arm_mf_r);
    txe_nxt = txe_r & ~(data_wr & arm_tx_r);
    mode_fault_flag_nxt = mode_fault_flag_r & ~(ctrl1_wr & arm_mode_fault_flag_r);
    if (data_rd) begin
      arm_rx_nxt = 1'b0;
      arm_mf_nxt = 1'b0;
    end
    if (data_wr) begin
      arm_tx_nxt = 1'b0;
      txbuf_nxt = len_r ? data_wdata : (data_wdata & LOW_BYTE_MASK);
      txfull_nxt = 1'b1;
    end
    if (match_wr) begin
      match_nxt = len_r ? match_wdata : (match_wdata & LOW_BYTE_MASK);
    end
    if (ctrl1_wr) begin
      arm_mode_fault_flag_nxt = 1'b0;
      en_nxt = wr_system_enable;
      mst_nxt = wr_master_select;
      mie_nxt = wr_main_irq_mask;
      tie_nxt = wr_transmit_irq_mask;
      soe_nxt = wr_select_output_enable;
    end
    if (ctrl2_wr) begin
      mmie_nxt = wr_match_irq_mask;
      len_nxt = wr_len16;
      mfe_nxt = wr_mode_fault_enable;
      boe_nxt = wr_bidir_output_enable;
      siw_nxt = wr_stop_in_wait;
      bsel_nxt = wr_bidir_select;
    end
    // buffer moves into a shifter: master at start, slave while deselected
    if (st_r == ST_IDLE && st_nxt == ST_RUN) begin
      txfull_nxt = 1'b0;
      txe_nxt = 1'b1;
    end else if (s_act & txfull_r & ss_s & ~frozen) begin
      slv_word_nxt = txbuf_r;
      txfull_nxt = 1'b0;
      txe_nxt = 1'b1;
    end
    // whole word lands, unless the last one is still unread
    if (rx_ev & ~rxf_r) begin
      rxbuf_nxt = rx_word;
      rxf_nxt = 1'b1;
      if (len_r ? (rx_word == match_r) : (rx_word[7:0] == match_r[7:0])) begin
        mf_nxt = 1'b1;
      end
    end
    // fault drops the master to a silent slave
    if (fault) begin
      mode_fault_flag_nxt = 1'b1;
      mst_nxt = 1'b0;
      if (bsel_r) begin
        boe_nxt = 1'b0;
      end
    end
    // with detection off as master the flag is held clear
    if (m_act & ~mfe_r) begin
      mode_fault_flag_nxt = 1'b0;
    end
    // masks only pass flags while enabled; fault request holds with flag
    irq_nxt = en_nxt & ((mie_nxt & (rxf_nxt | mode_fault_flag_nxt)) | (tie_nxt & txe_nxt)
      | (mmie_nxt & mf_nxt));
  end

  always_ff @(posedge mclk) begin
    if (rst_all) begin
      en_r <= CTRL_RESET;
      mst_r <= CTRL_RESET;
      mie_r <= CTRL_RESET;
      tie_r <= CTRL_RESET;
      soe_r <= CTRL_RESET;
      mmie_r <= CTRL_RESET;
      len_r <= CTRL_RESET;
      mfe_r <= CTRL_RESET;
      boe_r <= CTRL_RESET;
      siw_r <= CTRL_RESET;
      bsel_r <= CTRL_RESET;
      rxf_r <= FLAG_RESET;
      txe_r <= TX_EMPTY_RESET;
      mf_r <= FLAG_RESET;
      mode_fault_flag_r <= FLAG_RESET;
      arm_rx_r <= 1'b0;
      arm_tx_r <= 1'b0;
      arm_mf_r <= 1'b0;
      arm_mode_fault_flag_r <= 1'b0;
      txfull_r <= 1'b0;
      irq_r <= 1'b0;
      txbuf_r <= DATA_RESET;
      rxbuf_r <= DATA_RESET;
      match_r <= DATA_RESET;
      slv_word_r <= DATA_RESET;
      tog_prev_r <= 1'b0;
    end else begin
      en_r <= en_nxt;
      mst_r <= mst_nxt;
      mie_r <= mie_nxt;
      tie_r <= tie_nxt;
      soe_r <= soe_nxt;
      mmie_r <= mmie_nxt;
      len_r <= len_nxt;
      mfe_r <= mfe_nxt;
      boe_r <= boe_nxt;
      siw_r <= siw_nxt;
      bsel_r <= bsel_nxt;
      rxf_r <= rxf_nxt;
      txe_r <= txe_nxt;
      mf_r <= mf_nxt;
      mode_fault_flag_r <= mode_fault_flag_nxt;
      arm_rx_r <= arm_rx_nxt;
      arm_tx_r <= arm_tx_nxt;
      arm_mf_r <= arm_mf_nxt;
      arm_mode_fault_flag_r <= arm_mode_fault_flag_nxt;
      txfull_r <= txfull_nxt;
      irq_r <= irq_nxt;
      txbuf_r <= txbuf_nxt;
      rxbuf_r <= rxbuf_nxt;
      match_r <= match_nxt;
      slv_word_r <= slv_word_nxt;
      tog_prev_r <= tog_prev_nxt;
    end
  end

  // ==========================================================
  // pin drive enables; a faulted or disabled block drives nothing
  always_comb begin
    sclk_oe_nxt = m_act & ~fault;
    mosi_oe_nxt = m_act & ~fault & (bsel_r ? boe_r : 1'b1);
    miso_oe_nxt = s_act & ~ss_s & (bsel_r ? boe_r : 1'b1);
    ss_oe_nxt = m_act & soe_r & mfe_r;
    ss_out_nxt = (st_nxt == ST_IDLE);
  end

  always_ff @(posedge mclk) begin
    if (rst_all) begin
      sclk_oe_r <= 1'b0;
      mosi_oe_r <= 1'b0;
      miso_oe_r <= 1'b0;
      ss_oe_r <= 1'b0;
      ss_out_r <= 1'b1;
    end else begin
      sclk_oe_r <= sclk_oe_nxt;
      mosi_oe_r <= mosi_oe_nxt;
      miso_oe_r <= miso_oe_nxt;
      ss_oe_r <= ss_oe_nxt;
      ss_out_r <= ss_out_nxt;
    end
  end

  // ==========================================================
  // outputs, each straight from a flip-flop
  assign sclk_out = sclk_r;
  assign sclk_oe = sclk_oe_r;
  assign mosi_out = mout_r;
  assign mosi_oe = mosi_oe_r;
  assign miso_out = link_dout; // link-clock flop
  assign miso_oe = miso_oe_r;
  assign ss_n_out = ss_out_r;
  assign ss_n_oe = ss_oe_r;
  assign system_enable = en_r;
  assign master_select = mst_r;
  assign bidir_output_enable = boe_r;
  assign receive_full_flag = rxf_r;
  assign transmit_empty_flag = txe_r;
  assign match_flag = mf_r;
  assign mode_fault_flag = mode_fault_flag_r;
  assign rx_data = rxbuf_r;
  assign irq = irq_r;
endmodule // spi_core

// ==== spi_core_assertions.sv ====
`timescale 1ns/1ps
module spi_core_assertions
  import spi_pkg::*;
(
  input wire logic mclk, // clock
  input wire logic reset, // reset
  input wire logic deep_stop, // resets too
  input wire logic stop3_mode, // freeze
  input wire logic ctrl1_wr, // write
  input wire logic sclk_out, // clock pin
  input wire logic sclk_oe, // drive
  input wire logic mosi_oe, // drive
  input wire logic miso_oe, // drive
  input wire logic system_enable, // on
  input wire logic master_select, // master
  input wire logic bidir_output_enable, // pin out
  input wire logic receive_full_flag, // flag
  input wire logic transmit_empty_flag, // flag
  input wire logic match_flag, // flag
  input wire logic mode_fault_flag, // flag
  input wire logic [WORD_W-1:0] rx_data, // buffer
  input wire logic irq // request
);
  // ==========
  // one domain; deep stop clears like reset, so it masks the checks
  default clocking @(posedge mclk);
  endclocking
  default disable iff (reset || deep_stop);
  logic any_flag;
  // flags that a mask may pass on
  assign any_flag = receive_full_flag | transmit_empty_flag | match_flag | mode_fault_flag;
  slave_no_fault_a: assert property (
    $rose(mode_fault_flag) |-> $past(master_select)) else $error("fault as slave");
  fault_drop_a: assert property (
    $rose(mode_fault_flag) |-> ##[0:1] (!master_select && !sclk_oe && !mosi_oe && !miso_oe))
    else $error("fault left drivers on");
  fault_bidir_a: assert property (
    $rose(mode_fault_flag) |-> ##[0:1] !bidir_output_enable) else $error("pin out after fault");
  clock_dir_a: assert property (
    sclk_oe |-> master_select || $past(master_select)) else $error("clock driven as slave");
  irq_cause_a: assert property (
    irq |-> (system_enable || $past(system_enable)) && (any_flag || $past(any_flag)))
    else $error("stray request");
  fault_clear_a: assert property (
    $fell(mode_fault_flag) |-> $past(ctrl1_wr)) else $error("fault flag dropped alone");
  rx_hold_a: assert property (
    receive_full_flag && $past(receive_full_flag) |-> $stable(rx_data)) else $error("overrun");
  reset_zero_a: assert property (
    $fell(reset) |-> rx_data == '0 && transmit_empty_flag) else $error("reset values");
  off_quiet_a: assert property (
    !system_enable && !$past(system_enable) |-> !sclk_oe && !mosi_oe && !miso_oe)
    else $error("pins driven while off");
  freeze_a: assert property (
    $past(stop3_mode) && $past(stop3_mode, 2) |-> $stable(sclk_out))
    else $error("clock moved in stop3");
endmodule // spi_core_assertions

bind spi_core spi_core_assertions u_chk (.mclk, .reset, .deep_stop, .stop3_mode, .ctrl1_wr,
  .sclk_out, .sclk_oe, .mosi_oe, .miso_oe, .system_enable, .master_select, .bidir_output_enable,
  .receive_full_flag, .transmit_empty_flag, .match_flag, .mode_fault_flag, .rx_data, .irq);

// ==== spi_far_master.sv ====
`timescale 1ns/1ps
module spi_far_master (
  input wire logic lclk, // free link clock
  input wire logic miso, // from slave
  output logic sclk, // still between frames
  output logic ss_n, // select, active low
  output logic mosi, // to slave
  output logic [15:0] got // word read back
);
  // idle levels
  initial {sclk, ss_n, mosi, got} = {3'b010, 16'h0000};
  // msb first, drive on rise, sample on fall; a half bit is a whole link
  // period so the slave gets at least 6 bus clocks per half
  task automatic send(input logic [15:0] w, input int n);
    @(posedge lclk);
    ss_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge lclk);
      sclk = 1'b1;
      mosi = w[i];
      @(posedge lclk);
      sclk = 1'b0;
      got = {got[14:0], miso};
    end
    @(posedge lclk);
    ss_n = 1'b1;
    mosi = ~mosi; // released line keeps no stale value
  endtask
endmodule // spi_far_master

// ==== spi_pkg.sv ====
package spi_pkg;
  // ==========================================================
  // word sizes
  localparam int WORD_W = 16;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] TOP_BIT_16 = 5'h0F;
  localparam logic [CNT_W-1:0] TOP_BIT_8 = 5'h07;
  localparam logic [WORD_W-1:0] LOW_BYTE_MASK = 16'h00FF;
  // ==========================================================
  // master bit timing: bus clocks per half serial clock period
  localparam int HALF_BIT_CYCLES = 4;
  localparam int DIV_W = 8;
  // ==========================================================
  // reset values
  localparam logic [WORD_W-1:0] DATA_RESET = 16'h0000;
  localparam logic TX_EMPTY_RESET = 1'b1;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic CTRL_RESET = 1'b0;
  // ==========================================================
  // master sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01
  } mstate_type;
endpackage

// ==== sync2.sv ====
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  input wire logic mclk, // bus clock
  input wire logic reset, // synchronous, active high
  input wire logic [W-1:0] d, // asynchronous inputs
  output logic [W-1:0] q // synchronised copy
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // ==========================================================
  // two stages; the first is read only by the second
  always_ff @(posedge mclk) begin
    if (reset) begin
      meta_r <= '1;
      q_r <= '1;
    end else begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;
endmodule // sync2

// ==== test_spi_bidir_fault_lowpower_irq.sv ====
`timescale 1ns/1ps
module test_spi_bidir_fault_lowpower_irq
  import spi_pkg::*;
;
  logic mclk, reset, lclk, ss_pull, far_sclk, far_ss, far_mosi, sclk_in, sclk_out, sclk_oe;
  logic mosi_in, mosi_out, mosi_oe, miso_in, miso_out, miso_oe, ss_n_in, ss_n_out, ss_n_oe;
  logic ctrl1_wr, wr_system_enable, wr_master_select, wr_main_irq_mask, wr_transmit_irq_mask;
  logic wr_select_output_enable, ctrl2_wr, wr_match_irq_mask, wr_len16, wr_mode_fault_enable;
  logic wr_bidir_output_enable, wr_stop_in_wait, wr_bidir_select, status_rd, data_wr, data_rd;
  logic match_wr, wait_mode, stop3_mode, deep_stop, system_enable, master_select, irq;
  logic bidir_output_enable, receive_full_flag, transmit_empty_flag, match_flag, mode_fault_flag;
  logic [WORD_W-1:0] data_wdata, match_wdata, rx_data, far_got;
  int n_fail = 0;
  int n_tests = 0;
  typedef struct {logic len; logic [15:0] tx, mt, rx; logic mf; logic [1:0] frz;} row_type;
  // master rows: length, sent, match, expected word and match, freeze kind
  row_type rows [3] = '{'{1'b1, 16'hA55A, 16'hA55A, 16'hA55A, 1'b1, 2'h1},
    '{1'b0, 16'h12C3, 16'hFFC3, 16'h00C3, 1'b1, 2'h2},
    '{1'b0, 16'h003C, 16'h003D, 16'h003C, 1'b0, 2'h0}};
  // ==========
  // pins: an enabled driver wins, else far side; ss_pull forces select low over both; undriven miso reads the mosi pin, so a master hears itself
  assign sclk_in = sclk_oe ? sclk_out : far_sclk;
  assign mosi_in = mosi_oe ? mosi_out : far_mosi;
  assign miso_in = miso_oe ? miso_out : mosi_in;
  assign ss_n_in = (ss_n_oe ? ss_n_out : far_ss) & ~ss_pull;
  spi_core #(.HALF_CYCLES(HALF_BIT_CYCLES)) DUT (.mclk, .reset, .sclk_in, .sclk_out, .sclk_oe,
    .mosi_in, .mosi_out, .mosi_oe, .miso_in, .miso_out, .miso_oe, .ss_n_in, .ss_n_out, .ss_n_oe,
    .ctrl1_wr, .wr_system_enable, .wr_master_select, .wr_main_irq_mask, .wr_transmit_irq_mask,
    .wr_select_output_enable, .ctrl2_wr, .wr_match_irq_mask, .wr_len16, .wr_mode_fault_enable,
    .wr_bidir_output_enable, .wr_stop_in_wait, .wr_bidir_select, .status_rd, .data_wr,
    .data_wdata, .data_rd, .match_wr, .match_wdata, .wait_mode, .stop3_mode, .deep_stop,
    .system_enable, .master_select, .bidir_output_enable, .receive_full_flag,
    .transmit_empty_flag, .match_flag, .mode_fault_flag, .rx_data, .irq);
  spi_far_master u_far (.lclk(lclk), .miso(miso_in), .sclk(far_sclk), .ss_n(far_ss),
    .mosi(far_mosi), .got(far_got));
  // clocks: link clock free here, gated by the far side
  always #4 mclk = ~mclk;
  initial begin
    lclk = 1'b0;
    #3.1;
    forever #24 lclk = ~lclk;
  end
  // ==========
  // shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic pulse(input int k);
    case (k)
      0: status_rd <= 1'b1;
      1: data_rd <= 1'b1;
      2: data_wr <= 1'b1;
      3: match_wr <= 1'b1;
      4: ctrl1_wr <= 1'b1;
      default: ctrl2_wr <= 1'b1;
    endcase
    @(posedge mclk);
    {status_rd, data_rd, data_wr, match_wr, ctrl1_wr, ctrl2_wr} <= 6'h00;
    cyc(1);
  endtask
  task automatic c1(input logic [4:0] v);
    {wr_system_enable, wr_master_select, wr_main_irq_mask, wr_transmit_irq_mask,
     wr_select_output_enable} <= v;
    pulse(4);
  endtask
  task automatic c2(input logic [5:0] v);
    {wr_match_irq_mask, wr_len16, wr_mode_fault_enable, wr_bidir_output_enable,
     wr_stop_in_wait, wr_bidir_select} <= v;
    pulse(5);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wait_rx;
    int i;
    for (i = 0; i < 600 && receive_full_flag !== 1'b1; i++) begin
      cyc(1);
    end
    if (i == 600) begin
      n_fail++;
      $display("MISMATCH t=%0t no word", $time);
      end_of_test;
    end
    cyc(2);
  endtask
  // ==========
  // main sequence
  initial begin
    mclk = 1'b0;
    {reset, ss_pull, ctrl1_wr, ctrl2_wr, status_rd, data_wr, data_rd, match_wr} = 8'h80;
    {wr_system_enable, wr_master_select, wr_main_irq_mask, wr_transmit_irq_mask, wait_mode,
     wr_select_output_enable, wr_match_irq_mask, wr_len16, wr_mode_fault_enable, stop3_mode,
     wr_bidir_output_enable, wr_stop_in_wait, wr_bidir_select, deep_stop, data_wdata} = '0;
    match_wdata = '0;
    cyc(4);
    reset <= 1'b0;
    cyc(1);
    chk(rx_data, 16'h0000, "rx after reset");
    chk(16'(transmit_empty_flag), 16'h0001, "tx empty after reset");
    $display("reset test done");
    c1(5'h1C);
    foreach (rows[r]) begin
      c2({1'b1, rows[r].len, 2'b00, rows[r].frz == 2'h2, 1'b0});
      match_wdata <= rows[r].mt;
      pulse(3);
      data_wdata <= rows[r].tx;
      pulse(0);
      pulse(2);
      if (rows[r].frz != 2'h0) begin
        cyc(20);
        stop3_mode <= rows[r].frz == 2'h1;
        wait_mode <= rows[r].frz == 2'h2;
        cyc(40);
        {stop3_mode, wait_mode} <= 2'b00;
      end
      wait_rx;
      chk(rx_data, rows[r].rx, "master word");
      chk(16'(match_flag), 16'(rows[r].mf), "match");
      chk(16'({irq, transmit_empty_flag}), 16'h0003, "rx request");
      pulse(0);
      pulse(1);
      chk(16'(receive_full_flag), 16'h0000, "rx clear");
      $display("master row %0d done", r);
    end
    // slave: reply word, then an unserviced second frame
    c1(5'h14);
    c2(6'h10);
    data_wdata <= 16'h3CA5;
    pulse(2);
    u_far.send(16'h9E17, 16);
    wait_rx;
    chk(rx_data, 16'h9E17, "slave word");
    chk(far_got, 16'h3CA5, "slave reply");
    u_far.send(16'h0F0F, 16);
    cyc(10);
    chk(rx_data, 16'h9E17, "overrun");
    chk(16'(mode_fault_flag), 16'h0000, "slave fault");
    pulse(0);
    pulse(1);
    $display("slave test done");
    // bidir master, select pulled low with detection off then on
    c1(5'h1C);
    c2(6'h05);
    cyc(2);
    chk(16'({sclk_oe, mosi_oe, miso_oe}), 16'h0006, "bidir pins");
    ss_pull <= 1'b1;
    cyc(6);
    chk(16'(mode_fault_flag), 16'h0000, "fault while off");
    c1(5'h1D);
    c2(6'h0D);
    cyc(6);
    chk(16'({mode_fault_flag, ss_n_oe, ss_n_out}), 16'h0003, "select out");
    // let the select synchroniser see the release before detection goes live
    ss_pull <= 1'b0;
    cyc(3);
    c1(5'h1C);
    ss_pull <= 1'b1;
    cyc(6);
    chk(16'({mode_fault_flag, master_select, bidir_output_enable}), 16'h0004,
      "fault");
    ss_pull <= 1'b0;
    cyc(4);
    chk(16'({mode_fault_flag, irq}), 16'h0003, "fault request");
    pulse(0);
    c1(5'h1C);
    cyc(1);
    chk(16'({mode_fault_flag, irq}), 16'h0000, "fault cleared");
    $display("fault test done");
    deep_stop <= 1'b1;
    cyc(3);
    deep_stop <= 1'b0;
    cyc(3);
    chk(16'({system_enable, master_select, transmit_empty_flag}), 16'h0001,
      "deep stop");
    c1(5'h02);
    cyc(1);
    chk(16'(irq), 16'h0000, "request while off");
    c1(5'h12);
    cyc(1);
    chk(16'(irq), 16'h0001, "tx empty request");
    $display("low power test done");
    end_of_test;
  end
endmodule // test_spi_bidir_fault_lowpower_irq
